// *** rtl/spi_usart_pkg.sv ***
// constants and types shared by the master-spi serial port files
// assumes an 8-bit register port and one 50 MHz clock
package spi_usart_pkg;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] STATUS_ADDR = 8'hc0;
  localparam logic [7:0] ENABLE_ADDR = 8'hc1;
  localparam logic [7:0] MODE_ADDR = 8'hc2;
  localparam logic [7:0] BAUD_LOW_ADDR = 8'hc4;
  localparam logic [7:0] BAUD_HIGH_ADDR = 8'hc5;
  localparam logic [7:0] DATA_ADDR = 8'hc6;

  // ****************************************
  // field positions
  // ****************************************
  localparam int RX_DONE_BIT = 7;
  localparam int TX_DONE_BIT = 6;
  localparam int TX_EMPTY_BIT = 5;
  localparam int RX_IRQ_EN_BIT = 7;
  localparam int TX_IRQ_EN_BIT = 6;
  localparam int EMPTY_IRQ_EN_BIT = 5;
  localparam int RX_EN_BIT = 4;
  localparam int TX_EN_BIT = 3;
  localparam int MODE_HIGH_BIT = 7;
  localparam int MODE_LOW_BIT = 6;
  localparam int ORDER_BIT = 2;
  localparam int PHASE_BIT = 1;
  localparam int POLARITY_BIT = 0;

  // ****************************************
  // reset values and masks
  // ****************************************
  localparam logic [7:0] STATUS_RESET = 8'h20;
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [7:0] MODE_RESET = 8'h06;
  localparam logic [7:0] ENABLE_READ_MASK = 8'hf8;
  localparam logic [4:0] STATUS_LOW_ZERO = 5'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;
  localparam logic [3:0] HALF_FIRST = 4'h0;
  localparam logic [3:0] HALF_LAST = 4'hf;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0]
  {
    MODE_ASYNC = 2'h0,
    MODE_SYNC = 2'h1,
    MODE_RESERVED = 2'h2,
    MODE_MASTER_SPI = 2'h3
  } mode_type;

  typedef enum logic [1:0]
  {
    IDLE_STATE = 2'h1,
    SHIFT_STATE = 2'h2
  } shift_state_type;

endpackage

// *** rtl/baud_tick_gen.sv ***
// half-period tick generator for the serial clock
// assumes the divisor is stable while a frame runs
module baud_tick_gen #(
  parameter int WIDTH = 12
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic run,
  input wire logic [WIDTH-1:0] divisor,
  output logic tick
);
  import spi_usart_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] count;
    logic tick;
  } div_type;

  div_type r_reg;
  div_type r_next;
  logic wrap;

  assign wrap = (r_reg.count == divisor);
  assign tick = r_reg.tick;

  always_comb
  begin
    r_next = r_reg;
    // one tick every divisor+1 cycles, so a full sck period is 2*(divisor+1)
    r_next.tick = run && wrap; // R24
    if (!run || wrap)
    begin
      r_next.count = '0;
    end
    else
    begin
      r_next.count = WIDTH'(r_reg.count + 1'b1);
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      r_reg <= '0;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

endmodule

// *** rtl/rx_byte_fifo.sv ***
// small receive buffer with registered read data
// assumes pop is issued only by a bus read of the data register
module rx_byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic flush,
  input wire logic push,
  input wire logic [WIDTH-1:0] push_data,
  input wire logic pop,
  output logic [WIDTH-1:0] pop_data,
  output logic not_empty
);
  import spi_usart_pkg::*;

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [CNT_W-1:0] count;
    logic [WIDTH-1:0] dout;
  } fifo_type;

  fifo_type r_reg;
  fifo_type r_next;
  logic do_push;
  logic do_pop;

  assign pop_data = r_reg.dout;
  assign not_empty = (r_reg.count != '0);

  always_comb
  begin
    r_next = r_reg;
    // a full buffer drops the newest byte and keeps the older ones
    do_push = push && (r_reg.count != CNT_FULL); // R23
    do_pop = pop && (r_reg.count != '0);
    if (do_push)
    begin
      r_next.mem[r_reg.wr_ptr] = push_data;
      r_next.wr_ptr = (r_reg.wr_ptr == PTR_LAST) ? '0 : PTR_W'(r_reg.wr_ptr + 1'b1);
    end
    if (do_pop)
    begin
      r_next.dout = r_reg.mem[r_reg.rd_ptr];
      r_next.rd_ptr = (r_reg.rd_ptr == PTR_LAST) ? '0 : PTR_W'(r_reg.rd_ptr + 1'b1);
    end
    if (do_push && !do_pop)
    begin
      r_next.count = CNT_W'(r_reg.count + 1'b1);
    end
    else if (do_pop && !do_push)
    begin
      r_next.count = CNT_W'(r_reg.count - 1'b1);
    end
    if (flush)
    begin
      r_next.count = '0;
      r_next.wr_ptr = '0;
      r_next.rd_ptr = '0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      r_reg <= '0;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

endmodule

// *** rtl/usart_master_spi.sv ***
// serial port running as an spi master, registers on a plain 8-bit port
// assumes receive_pin is synchronous to clock; the slave select is software's job
// Summary of operation
// R1 - rx flag reads one while buffer holds data
// R2 - receiver disable flushes buffer, clears rx flag
// R3 - tx done when frame out, buffer empty
// R4 - tx done cleared by irq service or write-one
// R5 - empty flag set when buffer free, reset 0x20
// R6 - software writes zeros to reserved bits
// R7 - rx irq needs enable, global flag, rx flag
// R8 - tx irq needs enable, global flag, tx flag
// R9 - empty irq needs enable, global flag, empty flag
// R10 - receiver enable takes over receive pin
// R11 - transmitter enable takes over transmit pin
// R12 - tx disable waits for shifter and buffer empty
// R13 - two-bit mode field, 11 is master spi
// R14 - bit order one means lsb first
// R15 - phase picks leading or trailing sample edge
// R16 - polarity sets sck idle level
// R17 - format bits accepted with mode write
// R18 - double buffered tx, extra rx level
// R19 - master only, no slave select pin
// R20 - no collision flag, no double speed
// R21 - error flags always read zero
// R22 - data write starts each transfer
// R23 - rx overflow drops newest byte
// R24 - sck period is 2*(divider+1) cycles
//
// Strobed register access was left to the implementer.
module usart_master_spi #(
  parameter int BAUD_WIDTH = 12,
  parameter int RX_DEPTH = 2
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic global_irq_enable,
  input wire logic tx_done_irq_ack,
  output logic rx_done_irq,
  output logic tx_done_irq,
  output logic tx_empty_irq,
  output logic transmit_pin,
  output logic transmit_pin_oe_n,
  input wire logic receive_pin,
  output logic receive_pin_override,
  output logic transfer_clock_pin,
  output logic transfer_clock_pin_oe_n,
  output spi_usart_pkg::mode_type mode_field
);
  import spi_usart_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    shift_state_type state;
    logic [7:0] enable_ctl;
    logic [7:0] mode_fmt;
    logic [BAUD_WIDTH-1:0] baud;
    logic tx_done;
    logic tx_buf_full;
    logic [7:0] tx_buf;
    logic [7:0] tx_shift;
    logic [7:0] rx_shift;
    logic [3:0] half;
    logic sck;
    logic mosi;
    logic [7:0] rdata;
    logic data_sel;
  } port_type;

  port_type r_reg;
  port_type r_next;

  logic tick;
  logic spi_mode;
  logic lsb_first;
  logic cpha;
  logic cpol;
  logic tx_active;
  logic rx_flag;
  logic fifo_push;
  logic fifo_pop;
  logic [7:0] fifo_pop_data;
  logic [7:0] next_tx;

  // ****************************************
  // helpers
  // ****************************************
  baud_tick_gen #(
    .WIDTH(BAUD_WIDTH)
  ) divider (
    .clock(clock),
    .rst(rst),
    .run(r_reg.state == SHIFT_STATE),
    .divisor(r_reg.baud),
    .tick(tick)
  );

  rx_byte_fifo #(
    .WIDTH(8),
    .DEPTH(RX_DEPTH)
  ) rx_buffer (
    .clock(clock),
    .rst(rst),
    .flush(!r_reg.enable_ctl[RX_EN_BIT]), // R2
    .push(fifo_push),
    .push_data(r_next.rx_shift),
    .pop(fifo_pop),
    .pop_data(fifo_pop_data),
    .not_empty(rx_flag) // R1 R18
  );

  assign mode_field = mode_type'(r_reg.mode_fmt[MODE_HIGH_BIT:MODE_LOW_BIT]);
  assign spi_mode = (mode_field == MODE_MASTER_SPI); // R13
  assign lsb_first = r_reg.mode_fmt[ORDER_BIT];
  assign cpha = r_reg.mode_fmt[PHASE_BIT];
  assign cpol = r_reg.mode_fmt[POLARITY_BIT];

  // ****************************************
  // pins and interrupt requests
  // ****************************************
  // pin stays claimed until the last queued byte has left
  assign tx_active = r_reg.enable_ctl[TX_EN_BIT] || r_reg.tx_buf_full
    || (r_reg.state == SHIFT_STATE); // R11 R12
  assign transmit_pin = r_reg.mosi; // R19
  assign transmit_pin_oe_n = !tx_active; // R11 R12
  assign receive_pin_override = r_reg.enable_ctl[RX_EN_BIT]; // R10
  assign transfer_clock_pin = r_reg.sck ^ cpol; // R16
  assign transfer_clock_pin_oe_n = !(tx_active && spi_mode); // R19

  assign rx_done_irq = r_reg.enable_ctl[RX_IRQ_EN_BIT] && global_irq_enable
    && rx_flag; // R7
  assign tx_done_irq = r_reg.enable_ctl[TX_IRQ_EN_BIT] && global_irq_enable
    && r_reg.tx_done; // R8
  assign tx_empty_irq = r_reg.enable_ctl[EMPTY_IRQ_EN_BIT] && global_irq_enable
    && !r_reg.tx_buf_full; // R9

  // data register answers straight from the buffer's own read register
  assign reg_rdata = r_reg.data_sel ? fifo_pop_data : r_reg.rdata;

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    r_next = r_reg;
    r_next.data_sel = 1'b0;
    fifo_push = 1'b0;
    fifo_pop = 1'b0;
    next_tx = lsb_first ? {1'b0, r_reg.tx_shift[7:1]} : {r_reg.tx_shift[6:0], 1'b0};

    // register writes; clears come first so a same-cycle set wins
    if (reg_write)
    begin
      case (reg_addr)
        STATUS_ADDR:
        begin
          if (reg_wdata[TX_DONE_BIT])
          begin
            r_next.tx_done = 1'b0; // R4
          end
        end
        ENABLE_ADDR:
        begin
          r_next.enable_ctl = reg_wdata; // R10 R11
        end
        MODE_ADDR:
        begin
          // order, phase and polarity land with the mode bits in one write
          r_next.mode_fmt = reg_wdata; // R17
        end
        BAUD_LOW_ADDR:
        begin
          r_next.baud[7:0] = reg_wdata;
        end
        BAUD_HIGH_ADDR:
        begin
          r_next.baud[BAUD_WIDTH-1:8] = reg_wdata[BAUD_WIDTH-9:0]; // R20
        end
        DATA_ADDR:
        begin
          // a write into a full buffer is dropped silently, no collision flag
          if (r_reg.enable_ctl[TX_EN_BIT] && spi_mode && !r_reg.tx_buf_full)
          begin
            r_next.tx_buf = reg_wdata; // R22 R20
            r_next.tx_buf_full = 1'b1; // R5 R18
          end
        end
        default:
        begin
        end
      endcase
    end
    if (tx_done_irq_ack)
    begin
      r_next.tx_done = 1'b0; // R4
    end

    // register reads; unmapped offsets answer zero
    if (reg_read)
    begin
      case (reg_addr)
        STATUS_ADDR:
        begin
          r_next.rdata = {rx_flag, r_reg.tx_done, !r_reg.tx_buf_full,
            STATUS_LOW_ZERO}; // R1 R5 R21
        end
        ENABLE_ADDR:
        begin
          r_next.rdata = r_reg.enable_ctl & ENABLE_READ_MASK;
        end
        MODE_ADDR:
        begin
          r_next.rdata = r_reg.mode_fmt;
        end
        BAUD_LOW_ADDR:
        begin
          r_next.rdata = r_reg.baud[7:0];
        end
        BAUD_HIGH_ADDR:
        begin
          r_next.rdata = 8'(r_reg.baud[BAUD_WIDTH-1:8]);
        end
        DATA_ADDR:
        begin
          r_next.data_sel = 1'b1;
          fifo_pop = 1'b1;
        end
        default:
        begin
          r_next.rdata = READ_ZERO;
        end
      endcase
    end

    // shift engine
    case (r_reg.state)
      IDLE_STATE:
      begin
        r_next.sck = 1'b0;
        if (r_reg.tx_buf_full && spi_mode)
        begin
          r_next.tx_shift = r_reg.tx_buf; // R22
          r_next.tx_buf_full = 1'b0; // R5
          r_next.mosi = lsb_first ? r_reg.tx_buf[0] : r_reg.tx_buf[7]; // R14
          r_next.half = HALF_FIRST;
          r_next.state = SHIFT_STATE;
        end
      end
      SHIFT_STATE:
      begin
        if (tick)
        begin
          r_next.sck = !r_reg.sck;
          r_next.half = 4'(r_reg.half + 1'b1);
          // even half index is a leading edge; phase decides which edge samples
          if (r_reg.half[0] == cpha)
          begin
            r_next.rx_shift = lsb_first ? {receive_pin, r_reg.rx_shift[7:1]}
              : {r_reg.rx_shift[6:0], receive_pin}; // R15 R14
          end
          else if (r_reg.half != HALF_FIRST)
          begin
            r_next.tx_shift = next_tx;
            r_next.mosi = lsb_first ? next_tx[0] : next_tx[7]; // R14 R15
          end
          if (r_reg.half == HALF_LAST)
          begin
            fifo_push = r_reg.enable_ctl[RX_EN_BIT];
            if (r_reg.tx_buf_full)
            begin
              // back-to-back frame straight from the buffer
              r_next.tx_shift = r_reg.tx_buf; // R18
              r_next.tx_buf_full = 1'b0;
              r_next.mosi = lsb_first ? r_reg.tx_buf[0] : r_reg.tx_buf[7];
              r_next.half = HALF_FIRST;
            end
            else
            begin
              r_next.tx_done = 1'b1; // R3
              r_next.state = IDLE_STATE;
            end
          end
        end
      end
      default:
      begin
        r_next.state = IDLE_STATE;
      end
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      r_reg <= '0;
      r_reg.state <= IDLE_STATE;
      r_reg.enable_ctl <= ENABLE_RESET;
      r_reg.mode_fmt <= MODE_RESET;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

endmodule

// *** tb/usart_master_spi_sva.sv ***
// checker for the master-spi serial port, seeing only its top ports
// assumes one clock and a synchronous active-high reset
module usart_master_spi_sva
  import spi_usart_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic global_irq_enable,
  input wire logic rx_done_irq,
  input wire logic tx_done_irq,
  input wire logic tx_empty_irq,
  input wire logic transmit_pin_oe_n,
  input wire logic receive_pin_override,
  input wire logic transfer_clock_pin_oe_n,
  input spi_usart_pkg::mode_type mode_field
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire status_rd = reg_read && reg_addr == STATUS_ADDR;
  wire enable_wr = reg_write && reg_addr == ENABLE_ADDR;

  // ****************************************
  // interrupt requests
  // ****************************************
  // a request may only stand while the flag read in the same cycle is set
  property p_rx_irq_flag;
    status_rd && rx_done_irq |=> reg_rdata[RX_DONE_BIT];
  endproperty
  a_rx_irq_flag: assert property (p_rx_irq_flag)
    else $error("rx request without rx flag");
  property p_tx_irq_flag;
    status_rd && tx_done_irq |=> reg_rdata[TX_DONE_BIT];
  endproperty
  a_tx_irq_flag: assert property (p_tx_irq_flag)
    else $error("tx request without tx flag");
  property p_empty_irq_flag;
    status_rd && tx_empty_irq |=> reg_rdata[TX_EMPTY_BIT];
  endproperty
  a_empty_irq_flag: assert property (p_empty_irq_flag)
    else $error("empty request without empty flag");
  property p_irq_global;
    !global_irq_enable |-> !(rx_done_irq || tx_done_irq || tx_empty_irq);
  endproperty
  a_irq_global: assert property (p_irq_global)
    else $error("request while globally masked");

  // ****************************************
  // registers and pins
  // ****************************************
  property p_status_low_zero;
    status_rd |=> reg_rdata[4:0] == STATUS_LOW_ZERO;
  endproperty
  a_status_low_zero: assert property (p_status_low_zero)
    else $error("unused status bits not zero");
  property p_mode_field;
    reg_write && reg_addr == MODE_ADDR |=> mode_field == $past(reg_wdata[7:6]);
  endproperty
  a_mode_field: assert property (p_mode_field)
    else $error("mode field does not follow write");
  property p_rx_override;
    enable_wr |=> receive_pin_override == $past(reg_wdata[RX_EN_BIT]);
  endproperty
  a_rx_override: assert property (p_rx_override)
    else $error("receive pin override wrong");
  property p_tx_claim;
    enable_wr && reg_wdata[TX_EN_BIT] |=> !transmit_pin_oe_n;
  endproperty
  a_tx_claim: assert property (p_tx_claim)
    else $error("transmit pin not claimed");
  property p_clock_claim;
    !transfer_clock_pin_oe_n |-> ##[0:1] !transmit_pin_oe_n;
  endproperty
  a_clock_claim: assert property (p_clock_claim)
    else $error("transmit pin released during frame");
endmodule

bind usart_master_spi usart_master_spi_sva checker_i (.clock, .rst, .reg_addr, .reg_wdata,
  .reg_write, .reg_read, .reg_rdata, .global_irq_enable, .rx_done_irq, .tx_done_irq,
  .tx_empty_irq, .transmit_pin_oe_n, .receive_pin_override, .transfer_clock_pin_oe_n,
  .mode_field);

// *** tb/spi_slave_model.sv ***
// spi slave stand-in: shifts tx_byte out on miso, gathers mosi into rx_byte
// assumes select rises only after the format inputs are settled
module spi_slave_model (
  input wire logic clock,
  input wire logic select,
  input wire logic sck,
  input wire logic mosi,
  input wire logic cpha,
  input wire logic cpol,
  input wire logic lsb_first,
  input wire logic [7:0] tx_byte,
  output logic miso,
  output logic [7:0] rx_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sck_prev = 1'b0;
  logic last = 1'b0;
  int idx = 0;
  wire lead = sck_prev == cpol && sck != cpol;
  wire trail = sck_prev != cpol && sck == cpol;
  always @(posedge clock)
  begin
    sck_prev <= sck;
    last <= miso;
    if (!select)
      idx <= cpha ? -1 : 0;
    else if (cpha ? lead : trail)
      idx <= idx + 1;
    if (select && (cpha ? trail : lead))
      rx_byte <= lsb_first ? {mosi, rx_byte[7:1]} : {rx_byte[6:0], mosi};
  end
  // deselected line toggles so a stale bit can never pass as data
  always_comb
    if (select && idx >= 0)
      miso = tx_byte[lsb_first ? idx % 8 : 7 - idx % 8];
    else
      miso = ~last;
endmodule

// *** tb/usart_master_spi_bench.sv ***
// self-checking bench for the master-spi serial port
// assumes the slave model stands on the serial pins
module usart_master_spi_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import spi_usart_pkg::*;
  logic clock, rst, reg_write, reg_read, global_irq_enable, tx_done_irq_ack;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, slave_tx, slave_rx;
  logic rx_done_irq, tx_done_irq, tx_empty_irq, transmit_pin, transmit_pin_oe_n;
  logic receive_pin, receive_pin_override, transfer_clock_pin, transfer_clock_pin_oe_n;
  logic select, cpha, cpol, lsb;
  mode_type mode_field;
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;

  usart_master_spi DUT (.clock, .rst, .reg_addr, .reg_wdata, .reg_write, .reg_read,
    .reg_rdata, .global_irq_enable, .tx_done_irq_ack, .rx_done_irq, .tx_done_irq,
    .tx_empty_irq, .transmit_pin, .transmit_pin_oe_n, .receive_pin, .receive_pin_override,
    .transfer_clock_pin, .transfer_clock_pin_oe_n, .mode_field);
  spi_slave_model slave (.clock, .select, .sck(transfer_clock_pin), .mosi(transmit_pin),
    .cpha, .cpol, .lsb_first(lsb), .tx_byte(slave_tx), .miso(receive_pin), .rx_byte(slave_rx));

  always #10 clock = ~clock;
  // a hung poll must still reach the verdict
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 10000)
    begin
      fail_count++;
      summarize();
    end
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic summarize();
    if (fail_count == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string name);
    logic [7:0] d;
    rd(a, d);
    chk(name, exp, d);
  endtask
  task automatic wait_done();
    logic [7:0] s;
    s = 8'h00;
    for (int n = 0; n < 100 && s[TX_DONE_BIT] !== 1'b1; n++)
      rd(STATUS_ADDR, s);
    repeat (2) @(posedge clock);
    #1 chk("done seen", 8'h40, s & 8'h40);
  endtask
  task automatic frame(input logic [2:0] fmt, input logic [7:0] out_b, input logic [7:0] in_b);
    wr(STATUS_ADDR, 8'h40);
    wr(MODE_ADDR, {5'b11000, fmt});
    cpol <= fmt[0];
    cpha <= fmt[1];
    lsb <= fmt[2];
    slave_tx <= in_b;
    @(posedge clock);
    #1 chk("sck idle", 8'(fmt[0]), 8'(transfer_clock_pin));
    select <= 1'b1;
    wr(DATA_ADDR, out_b);
    wait_done();
    select <= 1'b0;
    chk("slave rx", out_b, slave_rx);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    rchk(STATUS_ADDR, 8'h20, "status reset");
    rchk(ENABLE_ADDR, 8'h00, "enable reset");
    rchk(MODE_ADDR, 8'h06, "mode reset");
    rchk(8'hc3, 8'h00, "unmapped");
    chk("tx pin free", 8'h01, 8'(transmit_pin_oe_n));
  endtask
  task automatic t_setup();
    wr(BAUD_LOW_ADDR, 8'h01);
    wr(MODE_ADDR, 8'hc0);
    wr(ENABLE_ADDR, 8'h18);
    @(posedge clock);
    #1 chk("mode", 8'h03, 8'(mode_field));
    chk("pins", 8'h02, {5'h0, transfer_clock_pin_oe_n, receive_pin_override,
      transmit_pin_oe_n});
    rchk(ENABLE_ADDR, 8'h18, "enable");
  endtask
  task automatic t_modes();
    for (int i = 0; i < 8; i++)
    begin
      frame(i[2:0], 8'(8'h96 + i), 8'(8'h4b - i));
      rchk(STATUS_ADDR, 8'he0, "status full");
      rchk(DATA_ADDR, 8'(8'h4b - i), "rx data");
      rchk(STATUS_ADDR, 8'h60, "status drained");
    end
  endtask
  task automatic t_overflow();
    frame(3'h0, 8'h11, 8'ha1);
    frame(3'h0, 8'h22, 8'hb2);
    frame(3'h0, 8'h33, 8'hc3);
    rchk(DATA_ADDR, 8'ha1, "first kept");
    rchk(DATA_ADDR, 8'hb2, "second kept");
    rchk(STATUS_ADDR, 8'h60, "newest dropped");
    frame(3'h0, 8'h44, 8'hd4);
    wr(ENABLE_ADDR, 8'h08);
    rchk(STATUS_ADDR, 8'h60, "flushed");
    wr(ENABLE_ADDR, 8'h18);
  endtask
  task automatic t_burst();
    wr(STATUS_ADDR, 8'h40);
    select <= 1'b1;
    wr(DATA_ADDR, 8'h5a);
    wr(DATA_ADDR, 8'hc6);
    rchk(STATUS_ADDR, 8'h00, "both held");
    wait_done();
    select <= 1'b0;
    chk("burst tail", 8'hc6, slave_rx);
    rchk(DATA_ADDR, 8'hd4, "burst rx one");
    rchk(DATA_ADDR, 8'hd4, "burst rx two");
  endtask
  task automatic t_flags();
    wr(ENABLE_ADDR, 8'hf8);
    @(posedge clock);
    #1 chk("masked", 8'h00, {5'h0, rx_done_irq, tx_done_irq, tx_empty_irq});
    @(posedge clock);
    global_irq_enable <= 1'b1;
    frame(3'h0, 8'h0f, 8'hf0);
    chk("raised", 8'h07, {5'h0, rx_done_irq, tx_done_irq, tx_empty_irq});
    rchk(STATUS_ADDR, 8'he0, "irq flags");
    @(posedge clock);
    tx_done_irq_ack <= 1'b1;
    @(posedge clock);
    tx_done_irq_ack <= 1'b0;
    rchk(STATUS_ADDR, 8'ha0, "ack clears");
    rchk(DATA_ADDR, 8'hf0, "irq data");
    @(posedge clock);
    #1 chk("rx served", 8'h01, {5'h0, rx_done_irq, tx_done_irq, tx_empty_irq});
    wr(ENABLE_ADDR, 8'h18);
    @(posedge clock);
    #1 chk("disabled", 8'h00, {5'h0, rx_done_irq, tx_done_irq, tx_empty_irq});
    @(posedge clock);
    global_irq_enable <= 1'b0;
  endtask
  task automatic t_disable();
    int n;
    n = 0;
    wr(STATUS_ADDR, 8'h40);
    select <= 1'b1;
    wr(DATA_ADDR, 8'h3c);
    wr(ENABLE_ADDR, 8'h10);
    @(posedge clock);
    #1 chk("pin kept", 8'h00, 8'(transmit_pin_oe_n));
    // high phase of sck lasts divider+1 cycles
    @(posedge transfer_clock_pin);
    while (transfer_clock_pin === 1'b1)
    begin
      @(posedge clock);
      #1 n++;
    end
    chk("half period", 8'h02, 8'(n));
    wait_done();
    select <= 1'b0;
    chk("last frame", 8'h3c, slave_rx);
    repeat (2) @(posedge clock);
    #1 chk("pin released", 8'h03, {6'h0, transfer_clock_pin_oe_n,
      transmit_pin_oe_n});
    wr(DATA_ADDR, 8'h77);
    rchk(STATUS_ADDR, 8'he0, "write refused");
    wr(ENABLE_ADDR, 8'h18);
    // data writes outside master spi mode must not queue a byte
    wr(MODE_ADDR, 8'h00);
    wr(DATA_ADDR, 8'h55);
    rchk(STATUS_ADDR, 8'he0, "mode refused");
    chk("clock pin free", 8'h01, 8'(transfer_clock_pin_oe_n));
  endtask

  initial
  begin
    clock = 1'b0;
    rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
    global_irq_enable = 1'b0;
    tx_done_irq_ack = 1'b0;
    select = 1'b0;
    cpha = 1'b0;
    cpol = 1'b0;
    lsb = 1'b0;
    slave_tx = 8'h00;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    t_reset();
    t_setup();
    t_modes();
    t_overflow();
    t_burst();
    t_flags();
    t_disable();
    summarize();
  end
endmodule
